// [bml_asserts.sv]
// Port checker for the boot mode block
`timescale 1ns/10ps
module bml_asserts
    import bml_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pmap_external,
    input wire logic emi_addr_20bit,
    input wire logic ext_pspace_allowed,
    input wire logic osc_high_power_bit,
    input wire logic core_rd_gnt,
    input wire logic sec_rd_gnt,
    input wire logic core_wr_valid,
    input wire logic core_wr_word,
    input wire logic [FLASH_DW-1:0] core_wr_data,
    input wire logic flash_prog_strobe,
    input wire logic [FLASH_DW-1:0] flash_prog_data
);
    default clocking cb @(posedge clk_sys); endclocking
    // A frozen cycle moves no state, so nothing is expected of it
    default disable iff (srst || !clk_en);
    property p_excl; !(core_rd_gnt && sec_rd_gnt); endproperty
    a_excl: assert property (p_excl) else $error("two grants");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_answer; psel && penable && !$past(penable) |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_prog; core_wr_valid && core_wr_word |=> flash_prog_strobe
        && flash_prog_data == $past(core_wr_data); endproperty
    a_prog: assert property (p_prog) else $error("no strobe");
    property p_noprog; !(core_wr_valid && core_wr_word) |=>
        !flash_prog_strobe; endproperty
    a_noprog: assert property (p_noprog) else $error("stray");
    // Only a reset may reload the latched security state
    property p_hold; !$past(srst) |-> $stable(ext_pspace_allowed);
    endproperty
    a_hold: assert property (p_hold) else $error("secure moved");
    property p_map; pmap_external |-> ext_pspace_allowed; endproperty
    a_map: assert property (p_map) else $error("map secure");
    property p_emi; emi_addr_20bit |-> ext_pspace_allowed; endproperty
    a_emi: assert property (p_emi) else $error("emi secure");
    property p_osc; $fell(srst) |-> !osc_high_power_bit; endproperty
    a_osc: assert property (p_osc) else $error("osc reset");
endmodule : bml_asserts
bind bml_boot_mode bml_asserts bml_asserts_i (.clk_sys, .srst, .clk_en, .psel,
    .penable, .pready, .pmap_external, .emi_addr_20bit, .ext_pspace_allowed,
    .osc_high_power_bit, .core_rd_gnt, .sec_rd_gnt, .core_wr_valid,
    .core_wr_word, .core_wr_data, .flash_prog_strobe, .flash_prog_data);

// [bml_boot_mode.sv]
// Boot mode latch, program map select, oscillator control and flash paths
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
// Functional notes
// - Secure 0 boot 0: mode 0, 16 lines, no ext space, debug off.
// - Secure 0 with boot 1 at reset is invalid and acts as both bits 0.
// - Secure 1 boot 0: internal mode 0 with 16 address lines.
// - Both bits 1: external mode 1, width from the memory width strap.
// - The secure bit loads from flash security only in reset; later changes wait for reset.
// - Software writes to the secure bit never touch flash security.
// - Software may write the boot bit after reset to steer the map.
// - Software changes to the secure bit leave the program map alone.
// - The oscillator high power bit resets to 0.
// - Data flash reads go to the core or secondary bus, never both.
// - Boot bit 1 picks the external map unless secure was 0 at reset.
module bml_boot_mode
    import bml_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps and flash security state, asynchronous
    input wire logic external_boot_strap,
    input wire logic memory_width_strap,
    input wire logic flash_unsecured,
    // Resolved operating mode
    output logic pmap_external,
    output logic emi_addr_20bit,
    output logic debug_enable,
    output logic ext_pspace_allowed,
    output logic osc_high_power_bit,
    // Data flash read paths
    input wire logic core_rd_req,
    input wire logic sec_rd_req,
    output logic core_rd_gnt,
    output logic sec_rd_gnt,
    // Flash program path on the core write bus
    input wire logic core_wr_valid,
    input wire logic core_wr_word,
    input wire logic [FLASH_DW-1:0] core_wr_data,
    output logic flash_prog_strobe,
    output logic [FLASH_DW-1:0] flash_prog_data
);

    bml_state_s st;
    bml_state_s next_st;

    logic [NUM_PINS-1:0] pins_in;
    assign pins_in = {flash_unsecured, memory_width_strap,
                      external_boot_strap};

    always_comb begin
        logic acc;
        logic hit;
        logic done;
        logic clr_bad;
        logic set_bad;
        logic unsec;
        logic boot;
        logic [APB_DW-1:0] rd;
        acc = 1'b0;
        hit = 1'b0;
        done = 1'b0;
        clr_bad = 1'b0;
        set_bad = 1'b0;
        unsec = 1'b0;
        boot = 1'b0;
        rd = '0;
        next_st = st;

        // Three-stage synchroniser; stage one feeds only stage two
        next_st.sync_a = pins_in;
        next_st.sync_b = st.sync_a;
        next_st.sync_c = st.sync_b;
        for (int i = 0; i < NUM_PINS; i++) begin
            if (st.sync_b[i] == st.sync_c[i]) begin
                next_st.pin_flt[i] = st.sync_c[i];
            end
        end

        if (srst) begin
            // Straps sampled every reset cycle; last one before release wins
            unsec = st.pin_flt[PIN_UNSEC];
            boot = st.pin_flt[PIN_BOOT];
            next_st.secure_rst = unsec;
            next_st.secure_state_bit = unsec;
            // Secured part cannot boot externally
            next_st.boot_select_bit = boot & unsec;
            // Wide bus only in external mode
            next_st.wide_rst = boot & unsec & st.pin_flt[PIN_WIDTH];
            next_st.osc_high_power_bit = OSC_HIGH_POWER_RST;
            next_st.bad_wr = 1'b0;
            next_st.arb = ARB_IDLE;
            next_st.prog_strobe = 1'b0;
            next_st.prog_data = '0;
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata = '0;
        end else begin
            // APB: pready rises in the second access cycle
            acc = psel & penable;
            hit = (paddr == OFS_MODE) || (paddr == OFS_OSC) ||
                  (paddr == OFS_STAT);
            done = acc & st.pready;
            next_st.pready = acc & ~st.pready;
            if (acc & ~st.pready) begin
                next_st.pslverr = ~hit;
                unique case (paddr)
                    OFS_MODE: begin
                        rd[MODE_BOOT_SEL] = st.boot_select_bit;
                        rd[MODE_SECURE] = st.secure_state_bit;
                    end
                    OFS_OSC: begin
                        rd[OSC_HIGH_POWER] = st.osc_high_power_bit;
                    end
                    OFS_STAT: begin
                        rd[STAT_EXT_MAP] = st.map_ext;
                        rd[STAT_EMI_WIDE] = st.emi_wide;
                        rd[STAT_DBG_EN] = st.dbg_en;
                        rd[STAT_SEC_RST] = st.secure_rst;
                        rd[STAT_PSP_OK] = st.psp_ok;
                        rd[STAT_BAD_WR] = st.bad_wr;
                    end
                    default: begin
                        rd = '0;
                    end
                endcase
                next_st.prdata = pwrite ? '0 : rd;
            end else if (done) begin
                next_st.pslverr = 1'b0;
                next_st.prdata = '0;
            end

            // Writes land on the edge that completes the access
            if (done & pwrite & pstrb[0]) begin
                unique case (paddr)
                    OFS_MODE: begin
                        next_st.boot_select_bit =
                            pwdata[MODE_BOOT_SEL];
                        // Stored only; no path to flash security or map
                        next_st.secure_state_bit =
                            pwdata[MODE_SECURE];
                    end
                    OFS_OSC: begin
                        // Crystal and external clock need 1, resonator 0
                        next_st.osc_high_power_bit =
                            pwdata[OSC_HIGH_POWER];
                    end
                    OFS_STAT: begin
                        clr_bad = pwdata[STAT_BAD_WR];
                    end
                    default: begin
                        clr_bad = 1'b0;
                    end
                endcase
            end

            // Single owner at a time; the holder keeps the array
            unique case (st.arb)
                ARB_IDLE: begin
                    if (core_rd_req) begin
                        next_st.arb = ARB_CORE;
                    end else if (sec_rd_req) begin
                        next_st.arb = ARB_SEC;
                    end
                end
                ARB_CORE: begin
                    if (!core_rd_req) begin
                        next_st.arb = sec_rd_req ? ARB_SEC : ARB_IDLE;
                    end
                end
                ARB_SEC: begin
                    if (!sec_rd_req) begin
                        next_st.arb = core_rd_req ? ARB_CORE : ARB_IDLE;
                    end
                end
                default: begin
                    next_st.arb = ARB_IDLE;
                end
            endcase

            // Only word writes reach the flash unit
            next_st.prog_strobe = core_wr_valid & core_wr_word;
            if (core_wr_valid & core_wr_word) begin
                next_st.prog_data = core_wr_data;
            end
            set_bad = core_wr_valid & ~core_wr_word;
            // A new offence beats a clear in the same cycle
            next_st.bad_wr = (st.bad_wr & ~clr_bad) | set_bad;
        end

        // Map follows the boot bit only if unsecured at reset
        next_st.map_ext = next_st.boot_select_bit &
                          next_st.secure_rst;
        // Internal boot keeps 16 lines
        next_st.emi_wide = next_st.wide_rst;
        // Secured part: debug off, no external program space
        next_st.dbg_en = next_st.secure_rst;
        next_st.psp_ok = next_st.secure_rst;
    end

    // Clock enable freezes everything, reset included
    always_ff @(posedge clk_sys) begin
        if (clk_en) begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign pmap_external = st.map_ext;
    assign emi_addr_20bit = st.emi_wide;
    assign debug_enable = st.dbg_en;
    assign ext_pspace_allowed = st.psp_ok;
    assign osc_high_power_bit = st.osc_high_power_bit;
    assign core_rd_gnt = st.arb[1];
    assign sec_rd_gnt = st.arb[2];
    assign flash_prog_strobe = st.prog_strobe;
    assign flash_prog_data = st.prog_data;

endmodule : bml_boot_mode

// [bml_boot_mode_tb_top.sv]
// Testbench for the boot mode block
`timescale 1ns/10ps
module bml_boot_mode_tb_top
    import bml_pkg::*;
;
    logic clk_sys = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, es, d;
    logic pready, pslverr, er, b;
    logic [2:0] cfg = 3'h0;
    logic external_boot_strap, memory_width_strap, flash_unsecured;
    logic pmap_external, emi_addr_20bit, debug_enable, ext_pspace_allowed;
    logic osc_high_power_bit, core_rd_gnt, sec_rd_gnt, flash_prog_strobe;
    logic core_rd_req = 0, sec_rd_req = 0, core_wr_valid = 0;
    logic core_wr_word = 0, clk_en = 1;
    logic [15:0] core_wr_data = 16'h0, flash_prog_data, w;
    int err_count = 0, n_tests = 0, cyc = 0;
    // Byte strobes are held active: not under test here
    bml_boot_mode bml_boot_mode_i (.pstrb(4'hF), .*);
    bml_strap_model bml_strap_model_i (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic complete_run;
        $display("errors %0d tests %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys) penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb
    function automatic logic [31:0] exp_stat(input logic [2:0] c,
        input logic bs);
        logic u;
        u = c[PIN_UNSEC];
        return {27'h0, u, u, u, c[PIN_BOOT] & c[PIN_WIDTH] & u, bs & u};
    endfunction : exp_stat
    task automatic chk_mode(input logic [2:0] c, input logic bs);
        es = exp_stat(c, bs);
        chk("pins", {es[4], es[2:0]}, {ext_pspace_allowed, debug_enable,
            emi_addr_20bit, pmap_external});
        apb(1'b0, OFS_STAT, 32'h0);
        chk("status", es, rd);
    endtask : chk_mode
    initial begin
        void'($urandom(90324));
        for (int i = 0; i < 8; i++) begin
            cfg <= i[2:0];
            srst <= 1'b1;
            repeat (10) @(posedge clk_sys);
            srst <= 1'b0;
            repeat (2) @(posedge clk_sys);
            b = i[PIN_BOOT] & i[PIN_UNSEC];
            chk_mode(i[2:0], b);
            apb(1'b0, OFS_MODE, 32'h0);
            chk("mode", {30'h0, i[PIN_UNSEC], b}, rd);
            apb(1'b0, OFS_OSC, 32'h0);
            chk("osc", 32'h0, rd);
            cfg <= i[2:0] ^ 3'h4;
            d = $urandom;
            apb(1'b1, OFS_MODE, d);
            chk_mode(i[2:0], d[0]);
            apb(1'b0, OFS_MODE, 32'h0);
            chk("mode wr", {30'h0, d[1:0]}, rd);
        end
        apb(1'b1, OFS_OSC, 32'h1);
        apb(1'b0, OFS_OSC, 32'h0);
        chk("osc hi", 32'h3, {rd[0], osc_high_power_bit});
        apb(1'b1, OFS_OSC, 32'h0);
        chk("osc lo", 32'h0, osc_high_power_bit);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        core_rd_req <= 1'b1;
        sec_rd_req <= 1'b1;
        repeat (2) @(posedge clk_sys);
        chk("core first", {core_rd_gnt, sec_rd_gnt}, 2'h2);
        core_rd_req <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk("handoff", {core_rd_gnt, sec_rd_gnt}, 2'h1);
        repeat (100) begin
            core_rd_req <= 1'($urandom);
            sec_rd_req <= 1'($urandom);
            w = 16'($urandom);
            core_wr_data <= w;
            core_wr_valid <= 1'b1;
            core_wr_word <= 1'b1;
            @(posedge clk_sys) core_wr_valid <= 1'b0;
            @(posedge clk_sys) chk("strobe", 32'h1, flash_prog_strobe);
            chk("prog data", {16'h0, w}, flash_prog_data);
        end
        core_wr_valid <= 1'b1;
        core_wr_word <= 1'b0;
        @(posedge clk_sys) core_wr_valid <= 1'b0;
        @(posedge clk_sys) chk("no strobe", 32'h0, flash_prog_strobe);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("bad wr", exp_stat(3'h7, d[0]) | 32'h20, rd);
        apb(1'b1, OFS_STAT, 32'h20);
        apb(1'b0, OFS_STAT, 32'h0);
        chk("bad clr", exp_stat(3'h7, d[0]), rd);
        // A word write while the clock enable is low must not strobe
        clk_en <= 1'b0;
        core_wr_valid <= 1'b1;
        core_wr_word <= 1'b1;
        @(posedge clk_sys) core_wr_valid <= 1'b0;
        @(posedge clk_sys) chk("frozen", 32'h0, flash_prog_strobe);
        clk_en <= 1'b1;
        @(posedge clk_sys);
        complete_run();
    end
endmodule : bml_boot_mode_tb_top

// [bml_pkg.sv]
// Constants and types for the boot mode latch and program map select block
package bml_pkg;

    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;

    // Register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_OSC = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;

    // Operating mode register fields
    localparam int unsigned MODE_BOOT_SEL = 0;
    localparam int unsigned MODE_SECURE = 1;

    // Oscillator control register fields
    localparam int unsigned OSC_HIGH_POWER = 0;
    localparam logic OSC_HIGH_POWER_RST = 1'b0;

    // Status register fields
    localparam int unsigned STAT_EXT_MAP = 0;
    localparam int unsigned STAT_EMI_WIDE = 1;
    localparam int unsigned STAT_DBG_EN = 2;
    localparam int unsigned STAT_SEC_RST = 3;
    localparam int unsigned STAT_PSP_OK = 4;
    localparam int unsigned STAT_BAD_WR = 5;

    // Pin synchroniser layout
    localparam int unsigned NUM_PINS = 3;
    localparam int unsigned PIN_BOOT = 0;
    localparam int unsigned PIN_WIDTH = 1;
    localparam int unsigned PIN_UNSEC = 2;

    localparam int unsigned FLASH_DW = 16;

    typedef enum logic [2:0] {
        ARB_IDLE = 3'b001,
        ARB_CORE = 3'b010,
        ARB_SEC = 3'b100
    } bml_arb_e;

    typedef struct packed {
        logic [NUM_PINS-1:0] sync_a;
        logic [NUM_PINS-1:0] sync_b;
        logic [NUM_PINS-1:0] sync_c;
        logic [NUM_PINS-1:0] pin_flt;
        logic boot_select_bit;
        logic secure_state_bit;
        logic secure_rst;
        logic wide_rst;
        logic osc_high_power_bit;
        logic bad_wr;
        logic map_ext;
        logic emi_wide;
        logic dbg_en;
        logic psp_ok;
        bml_arb_e arb;
        logic prog_strobe;
        logic [FLASH_DW-1:0] prog_data;
        logic pready;
        logic pslverr;
        logic [APB_DW-1:0] prdata;
    } bml_state_s;

endpackage : bml_pkg

// [bml_strap_model.sv]
// Board straps and flash security state model
`timescale 1ns/10ps
module bml_strap_model
    import bml_pkg::*;
(
    input wire logic clk_sys,
    input wire logic [NUM_PINS-1:0] cfg,
    output logic external_boot_strap,
    output logic memory_width_strap,
    output logic flash_unsecured
);
    // Security may change at any time; the device must ignore it until reset
    always @(posedge clk_sys) begin
        external_boot_strap <= cfg[PIN_BOOT];
        memory_width_strap <= cfg[PIN_WIDTH];
        flash_unsecured <= cfg[PIN_UNSEC];
    end
endmodule : bml_strap_model
